// ==== common/reload_timer_params.svh ====
// Purpose: offsets, field positions, reset values and tap widths of the reload timer
// Assumes: included by bare name after the package
// Notes:   definitions only
`ifndef RELOAD_TIMER_PARAMS_SVH
`define RELOAD_TIMER_PARAMS_SVH

// ****************************************
// register map (byte offsets)
// ****************************************
`define OFS_CTRL        8'h00
`define OFS_COUNT       8'h04
`define OFS_RELOAD      8'h08
`define CH_STRIDE       8'h10
`define OFS_IRQ_STATUS  8'h40
`define OFS_IRQ_MASK    8'h44

// ****************************************
// control register fields
// ****************************************
`define CTRL_ENABLE     0
`define CTRL_RELOAD     1
`define CTRL_SRC_LSB    2
`define CTRL_USE_LSB    4
`define CTRL_START      6
`define CTRL_RUNNING    8

// ****************************************
// reset values
// ****************************************
`define CTRL_RESET      8'h00
`define RELOAD_RESET    16'h0000
`define MASK_RESET      4'h0

// ****************************************
// prescaler taps: divide by 2, 8, 32
// ****************************************
`define TAP0_BITS       1
`define TAP1_BITS       3
`define TAP2_BITS       5

`endif

// ==== common/reload_timer_pkg.sv ====
// Purpose: shared types of the reload timer
// Assumes: nothing
// Notes:   constants live in reload_timer_params.svh
package reload_timer_pkg;

    // count clock source
    typedef enum logic [1:0] {
        SRC_TAP0,
        SRC_TAP1,
        SRC_TAP2,
        SRC_EVENT
    } count_src_t;

    // use of the event input under an internal clock; code 3 acts as none
    typedef enum logic [1:0] {
        USE_NONE,
        USE_TRIGGER,
        USE_GATE
    } input_use_t;

endpackage

// ==== rtl/timer_channel.sv ====
// Purpose: one 16-bit reload down-timer channel
// Assumes: event_level already synchronised to mclk
// Notes:   all outputs are flops
`timescale 1ns/1ps
`default_nettype none
module timer_channel (
    input  wire logic                        mclk,
    input  wire logic                        rst_b,
    input  wire logic                        ce,
    input  wire logic                        enable,
    input  wire logic                        reload_mode,
    input  wire reload_timer_pkg::count_src_t count_src,
    input  wire reload_timer_pkg::input_use_t in_use,
    input  wire logic                        start,
    input  wire logic [15:0]                 reload_value,
    input  wire logic [2:0]                  tick,
    input  wire logic                        event_level,
    output logic      [15:0]                 count_value,
    output logic                             running,
    output logic                             pulse_out,
    output logic                             underflow
);
    import reload_timer_pkg::*;

    typedef struct packed {
        logic [15:0] count;
        logic        run;
        logic        out;
        logic        ev_prev;
        logic        uf;
    } chan_state_t;

    chan_state_t s;
    chan_state_t next_s;
    logic        ev_rise;
    logic        step;
    logic        gate_ok;
    logic        trig;

    always_comb begin
        next_s = s;
        next_s.uf = 1'b0;
        next_s.ev_prev = event_level;
        ev_rise = event_level & ~s.ev_prev;
        unique case (count_src)
            SRC_TAP0:  step = tick[0];    // RULE2
            SRC_TAP1:  step = tick[1];    // RULE2
            SRC_TAP2:  step = tick[2];    // RULE2
            SRC_EVENT: step = ev_rise;    // RULE5
        endcase
        // gate only applies with an internal clock
        gate_ok = (count_src == SRC_EVENT) || (in_use != USE_GATE) || event_level; // RULE6
        trig = start || ((count_src != SRC_EVENT) && (in_use == USE_TRIGGER) && ev_rise); // RULE6
        if (!enable) begin
            next_s.run = 1'b0;
            next_s.out = 1'b0;
        end else if (trig) begin
            next_s.count = reload_value;  // RULE1
            next_s.run = 1'b1;
            if (!reload_mode) begin
                next_s.out = 1'b1;        // RULE4
            end
        end else if (s.run && step && gate_ok) begin
            if (s.count == 16'h0000) begin
                next_s.uf = 1'b1;         // RULE10
                next_s.count = reload_value; // RULE11
                if (reload_mode) begin
                    next_s.out = ~s.out;  // RULE3
                end else begin
                    next_s.run = 1'b0;    // RULE11
                    next_s.out = 1'b0;    // RULE4
                end
            end else begin
                next_s.count = s.count - 16'h0001; // RULE1
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign count_value = s.count;
    assign running     = s.run;
    assign pulse_out   = s.out;
    assign underflow   = s.uf;

endmodule
`default_nettype wire

// ==== rtl/reload_down_timer.sv ====
// Purpose: four reload down-timer channels behind an AHB-Lite slave
// Assumes: single word transfers; haddr bits above 7 are not decoded
// Notes:   one wait state per transfer; response always OKAY
//
// What this block does
// RULE1 - 16-bit down counter loaded from reload register
// RULE2 - count clock: three internal taps or event pin
// RULE3 - reload mode toggles output at each period end
// RULE4 - single-shot output high while counter runs
// RULE5 - event mode counts rising edges of input pin
// RULE6 - internal clock: input pin is trigger or gate
// RULE7 - four independent channels with own registers, pins
// RULE8 - channel 2 output drives serial baud clock
// RULE9 - channel 3 output starts the analog converter
// RULE10 - each channel raises its own end-of-count interrupt
// RULE11 - underflow reloads; single-shot then stops until trigger
// RULE12 - count reads return live value, counting undisturbed
//
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "reload_timer_params.svh"
module reload_down_timer #(
    parameter int NUM_CH = 4
) (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              ce,
    // ****************************************
    // AHB-Lite slave
    // ****************************************
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic      [31:0]       hrdata,
    output logic                   hresp,
    // ****************************************
    // pins and links
    // ****************************************
    input  wire logic [NUM_CH-1:0] timer_event_input,
    output logic      [NUM_CH-1:0] timer_pulse_output,
    output logic                   baud_clock_out,
    output logic                   adc_timer_start,
    output logic                   irq
);
    import reload_timer_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [NUM_CH-1:0]         sync1;
        logic [NUM_CH-1:0]         sync2;
        logic [`TAP2_BITS-1:0]     presc;
        logic                      ready;
        logic                      resp;
        logic                      pending;
        logic                      wr;
        logic [7:0]                addr;
        logic [31:0]               rdata;
        logic [NUM_CH-1:0][7:0]    ctrl;
        logic [NUM_CH-1:0][15:0]   reload;
        logic [NUM_CH-1:0]         start;
        logic [NUM_CH-1:0]         status;
        logic [NUM_CH-1:0]         mask;
        logic [NUM_CH-1:0]         pout;
        logic                      baud;
        logic                      adc;
        logic                      irq;
    } top_state_t;

    top_state_t               s;
    top_state_t               next_s;
    logic [2:0]               tick;
    logic [NUM_CH-1:0]        clr;
    logic [NUM_CH-1:0][15:0]  ch_count;
    logic [NUM_CH-1:0]        ch_run;
    logic [NUM_CH-1:0]        ch_pout;
    logic [NUM_CH-1:0]        ch_uf;

    // ****************************************
    // prescaler taps
    // ****************************************
    // taps share one free-running counter so their phases stay related
    assign tick = {&s.presc[`TAP2_BITS-1:0],
                   &s.presc[`TAP1_BITS-1:0],
                   &s.presc[`TAP0_BITS-1:0]};

    // ****************************************
    // channels
    // ****************************************
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        timer_channel u_ch (         // RULE7
            .mclk         (mclk),
            .rst_b        (rst_b),
            .ce           (ce),
            .enable       (s.ctrl[g][`CTRL_ENABLE]),
            .reload_mode  (s.ctrl[g][`CTRL_RELOAD]),
            .count_src    (count_src_t'(s.ctrl[g][`CTRL_SRC_LSB +: 2])),
            .in_use       (input_use_t'(s.ctrl[g][`CTRL_USE_LSB +: 2])),
            .start        (s.start[g]),
            .reload_value (s.reload[g]),
            .tick         (tick),
            .event_level  (s.sync2[g]),
            .count_value  (ch_count[g]),
            .running      (ch_run[g]),
            .pulse_out    (ch_pout[g]),
            .underflow    (ch_uf[g])
        );
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_s = s;
        clr = '0;
        // pins cross in through two flops
        next_s.sync1 = timer_event_input;
        next_s.sync2 = s.sync1;
        next_s.presc = s.presc + `TAP2_BITS'(1);
        next_s.start = '0;
        next_s.resp = 1'b0;

        // data phase: one wait state, then answer
        if (s.pending) begin
            next_s.pending = 1'b0;
            next_s.ready = 1'b1;
            next_s.rdata = '0;
            for (int i = 0; i < NUM_CH; i++) begin
                if (s.addr == 8'(i) * `CH_STRIDE + `OFS_CTRL) begin
                    if (s.wr) begin
                        next_s.ctrl[i] = hwdata[7:0];
                        // start is a one-shot command, never stored
                        next_s.ctrl[i][`CTRL_START] = 1'b0;
                        next_s.start[i] = hwdata[`CTRL_START];
                    end else begin
                        next_s.rdata[7:0] = s.ctrl[i];
                        next_s.rdata[`CTRL_RUNNING] = ch_run[i];
                    end
                end
                if (s.addr == 8'(i) * `CH_STRIDE + `OFS_COUNT) begin
                    if (!s.wr) begin
                        next_s.rdata[15:0] = ch_count[i]; // RULE12
                    end
                end
                if (s.addr == 8'(i) * `CH_STRIDE + `OFS_RELOAD) begin
                    if (s.wr) begin
                        next_s.reload[i] = hwdata[15:0]; // RULE1
                    end else begin
                        next_s.rdata[15:0] = s.reload[i];
                    end
                end
            end
            if (s.addr == `OFS_IRQ_STATUS) begin
                if (s.wr) begin
                    clr = hwdata[NUM_CH-1:0];
                end else begin
                    next_s.rdata[NUM_CH-1:0] = s.status;
                end
            end
            if (s.addr == `OFS_IRQ_MASK) begin
                if (s.wr) begin
                    next_s.mask = hwdata[NUM_CH-1:0];
                end else begin
                    next_s.rdata[NUM_CH-1:0] = s.mask;
                end
            end
        end

        // address phase
        if (hsel && htrans[1] && hready) begin
            next_s.pending = 1'b1;
            next_s.ready = 1'b0;
            next_s.wr = hwrite;
            next_s.addr = haddr[7:0];
        end

        // a new underflow wins over a clear in the same cycle
        next_s.status = (s.status & ~clr) | ch_uf;  // RULE10
        next_s.irq = |(next_s.status & next_s.mask); // RULE10

        next_s.pout = ch_pout;
        next_s.baud = ch_pout[2];                    // RULE8
        next_s.adc = ch_pout[3];                     // RULE9
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.ready <= 1'b1;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign hreadyout          = s.ready;
    assign hrdata             = s.rdata;
    assign hresp              = s.resp;
    assign timer_pulse_output = s.pout;
    assign baud_clock_out     = s.baud;
    assign adc_timer_start    = s.adc;
    assign irq                = s.irq;

endmodule
`default_nettype wire

// ==== tb/reload_down_timer_sva.sv ====
// Purpose: bus and pin checks on the reload timer top
// Assumes: one clock domain, rst_b async low
// Notes:   bound to reload_down_timer
`timescale 1ns/1ps
`default_nettype none
module reload_down_timer_chk #(
    parameter int NUM_CH = 4
) (
    input wire logic              mclk,
    input wire logic              rst_b,
    input wire logic              ce,
    input wire logic              hsel,
    input wire logic [1:0]        htrans,
    input wire logic              hready,
    input wire logic              hreadyout,
    input wire logic [31:0]       hrdata,
    input wire logic              hresp,
    input wire logic [NUM_CH-1:0] timer_pulse_output,
    input wire logic              baud_clock_out,
    input wire logic              adc_timer_start,
    input wire logic              irq
);
    logic [1:0] wait_len;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_req;
        ce && hsel && htrans[1] && hready;
    endsequence
    sequence s_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    // saturates so a stuck wait cannot wrap back to a legal value
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            wait_len <= 2'h0;
        else if (hreadyout)
            wait_len <= 2'h0;
        else if (ce && wait_len != 2'h3)
            wait_len <= wait_len + 2'h1;
    end
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    chk_take_wait: assert property (s_req ##1 ce |-> s_wait)
        else $error("request not answered after one wait");
    chk_ready_idle: assert property (hreadyout && !(ce && hsel && htrans[1] && hready) |=> hreadyout)
        else $error("wait state without request");
    chk_wait_len: assert property (wait_len <= 2'h1)
        else $error("wait state too long");
    chk_rdata_hold: assert property ($past(hreadyout) && hreadyout |-> $stable(hrdata))
        else $error("read data moved between transfers");
    chk_freeze_all: assert property (!ce |=> $stable({timer_pulse_output, irq, hrdata}))
        else $error("state moved while clock enable low");
    chk_baud_copy: assert property (baud_clock_out == timer_pulse_output[2])
        else $error("baud clock differs from channel 2");
    chk_adc_copy: assert property (adc_timer_start == timer_pulse_output[3])
        else $error("converter start differs from channel 3");
endmodule
bind reload_down_timer reload_down_timer_chk #(.NUM_CH(NUM_CH)) u_chk (
    .mclk(mclk), .rst_b(rst_b), .ce(ce), .hsel(hsel), .htrans(htrans),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .timer_pulse_output(timer_pulse_output), .baud_clock_out(baud_clock_out),
    .adc_timer_start(adc_timer_start), .irq(irq)
);
`default_nettype wire

// ==== tb/timer_pins_model.sv ====
// Purpose: event source on the input pins, load on the output pins
// Assumes: driven from the bench by task calls
// Notes:   rises counts rising edges seen on each output
`timescale 1ns/1ps
`default_nettype none
module timer_pins_model (
    input  wire logic       mclk,
    input  wire logic [3:0] timer_pulse_output,
    output logic      [3:0] timer_event_input
);
    int         rises [4];
    logic [3:0] last;
    initial begin
        timer_event_input = 4'h0;
        last = 4'h0;
        rises = '{0, 0, 0, 0};
    end
    always @(posedge mclk) begin
        for (int i = 0; i < 4; i++)
            if (timer_pulse_output[i] && !last[i]) rises[i]++;
        last <= timer_pulse_output;
    end
    // w sets the speed: 1 is the fastest the synchroniser can see
    task automatic pulse(input int ch, input int n, input int w);
        repeat (n) begin
            @(posedge mclk);
            timer_event_input[ch] <= 1'b1;
            repeat (w) @(posedge mclk);
            timer_event_input[ch] <= 1'b0;
            repeat (w - 1) @(posedge mclk);
        end
    endtask
    task automatic level(input int ch, input logic v);
        @(posedge mclk);
        timer_event_input[ch] <= v;
    endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: register and pin tests of the four-channel reload timer
// Assumes: one wait state bus, taps /2 /8 /32
// Notes:   outputs are sampled at the falling edge
`timescale 1ns/1ps
`default_nettype none
`include "reload_timer_params.svh"
module testbench;
    logic        mclk, rst_b, ce, hsel, hwrite, hreadyout, hresp;
    logic        baud_clock_out, adc_timer_start, irq;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, q, c1, c2;
    logic [3:0]  timer_event_input, timer_pulse_output;
    int          n_fail, samples_checked, w;
    int          div [3] = '{1 << `TAP0_BITS, 1 << `TAP1_BITS, 1 << `TAP2_BITS};

    reload_down_timer #(.NUM_CH(4)) dut (
        .mclk(mclk), .rst_b(rst_b), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .timer_event_input(timer_event_input), .timer_pulse_output(timer_pulse_output),
        .baud_clock_out(baud_clock_out), .adc_timer_start(adc_timer_start), .irq(irq)
    );
    timer_pins_model pins (
        .mclk(mclk), .timer_pulse_output(timer_pulse_output),
        .timer_event_input(timer_event_input)
    );

    always #5 mclk = ~mclk;

    task automatic wrap_up();
        $display("compared %0d mismatched %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h want %h", $time, m, got, exp);
        end
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (n >= 100) begin
            n_fail++;
            wrap_up();
        end
        @(posedge mclk);
    endtask
    task automatic xfer(input int a, input logic wr_en, input logic [31:0] d);
        @(posedge mclk);
        haddr <= 32'(a);
        hwrite <= wr_en;
        htrans <= 2'h2;
        hsel <= 1'b1;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask
    task automatic wr(input int a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rd(input int a, output logic [31:0] v);
        xfer(a, 1'b0, 32'h0000_0000);
        v = hrdata;
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // cycles until the output pin of channel ch next changes
    task automatic gap(input int ch, output int c);
        logic v;
        c = 0;
        v = timer_pulse_output[ch];
        while (timer_pulse_output[ch] === v && c < 400) begin
            @(negedge mclk);
            c++;
        end
        // a pin that never moves is a hang, not a long period
        if (c >= 400) begin
            n_fail++;
            wrap_up();
        end
    endtask

    initial begin
        mclk = 1'b0;
        rst_b = 1'b0;
        ce = 1'b1;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        n_fail = 0;
        samples_checked = 0;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        for (int ch = 0; ch < 4; ch++) begin
            rd(ch * `CH_STRIDE + `OFS_CTRL, q);
            chk(q, 32'h0000_0000, "ctrl reset");
            rd(ch * `CH_STRIDE + `OFS_RELOAD, q);
            chk(q, 32'h0000_0000, "reload reset");
            wr(ch * `CH_STRIDE + `OFS_RELOAD, 32'hFFFF_0000 + 32'(ch + 1));
        end
        for (int ch = 0; ch < 4; ch++) begin
            rd(ch * `CH_STRIDE + `OFS_RELOAD, q);
            chk(q, 32'(ch + 1), "reload own");
        end
        rd(`OFS_IRQ_MASK, q);
        chk(q, 32'h0000_0000, "mask reset");
        wr(8'h4C, 32'hFFFF_FFFF);
        rd(8'h4C, q);
        chk(q, 32'h0000_0000, "unmapped");
        $display("test regs done");
        wr(`OFS_RELOAD, 32'h0000_0002);
        for (int k = 0; k < 3; k++) begin
            wr(`OFS_CTRL, 32'h0000_0000);
            wr(`OFS_CTRL, 32'h0000_0043 + 32'(4 * k));
            gap(0, w);
            gap(0, w);
            chk(w, 3 * div[k], "toggle period");
        end
        rd(`OFS_IRQ_STATUS, q);
        chk(q & 32'h0000_0001, 32'h0000_0001, "status set");
        chk(irq, 1'b0, "masked irq");
        wr(`OFS_IRQ_MASK, 32'h0000_0001);
        settle(3);
        chk(irq, 1'b1, "irq raised");
        wr(`OFS_CTRL, 32'h0000_0000);
        wr(`OFS_IRQ_STATUS, 32'h0000_0001);
        settle(3);
        chk(irq, 1'b0, "irq cleared");
        $display("test reload done");
        wr(`OFS_RELOAD, 32'h0000_0100);
        wr(`OFS_CTRL, 32'h0000_004B);
        rd(`OFS_COUNT, c1);
        settle(40);
        rd(`OFS_COUNT, c2);
        chk(32'(c1 - c2 inside {[1:2]} && c1 <= 32'h0000_0100), 1, "live count");
        @(posedge mclk);
        ce <= 1'b0;
        repeat (100) @(posedge mclk);
        ce <= 1'b1;
        rd(`OFS_COUNT, c1);
        chk(32'(c2 - c1 <= 1), 1, "frozen count");
        wr(`OFS_CTRL, 32'h0000_0000);
        $display("test count done");
        wr(16 + `OFS_RELOAD, 32'h0000_0004);
        wr(16 + `OFS_CTRL, 32'h0000_0011);
        fork
            pins.pulse(1, 1, 3);
            begin
                gap(1, w);
                gap(1, w);
            end
        join
        chk(32'(w inside {[9:10]}), 1, "one shot width");
        rd(16 + `OFS_CTRL, q);
        chk(q & 32'h0000_0100, 32'h0000_0000, "stopped");
        pins.pulse(1, 1, 3);
        settle(30);
        chk(pins.rises[1], 2, "retrigger");
        $display("test single done");
        pins.level(2, 1'b0);
        wr(32 + `OFS_RELOAD, 32'h0000_0003);
        wr(32 + `OFS_CTRL, 32'h0000_0063);
        rd(32 + `OFS_COUNT, c1);
        settle(20);
        rd(32 + `OFS_COUNT, c2);
        chk(c2, c1, "gate closed");
        pins.level(2, 1'b1);
        settle(40);
        chk(32'(pins.rises[2] >= 2), 1, "gate open");
        if (timer_pulse_output[2] !== 1'b1)
            gap(2, w);
        chk(baud_clock_out, 1'b1, "baud clock");
        wr(32 + `OFS_CTRL, 32'h0000_0000);
        $display("test gate done");
        wr(48 + `OFS_RELOAD, 32'h0000_0003);
        wr(48 + `OFS_CTRL, 32'h0000_004F);
        pins.pulse(3, 3, 4);
        settle(6);
        rd(`OFS_IRQ_STATUS, q);
        chk(q & 32'h0000_0008, 32'h0000_0000, "three events");
        pins.pulse(3, 1, 1);
        settle(8);
        rd(`OFS_IRQ_STATUS, q);
        chk(q & 32'h0000_0008, 32'h0000_0008, "fourth event");
        chk(pins.rises[3], 1, "converter start");
        chk(adc_timer_start, 1'b1, "converter level");
        $display("test event done");
        wrap_up();
    end
endmodule
`default_nettype wire
